//--- hw/fieldbus_image_pkg.sv
// Constants shared by the fieldbus process data image design
package fieldbus_image_pkg;
	// Register byte offsets on the APB side
	localparam logic [7:0] OFS_REQUEST    = 8'h00;
	localparam logic [7:0] OFS_REPLY      = 8'h04;
	localparam logic [7:0] OFS_CURR_INT   = 8'h08;
	localparam logic [7:0] OFS_CURR_FLT   = 8'h0c;
	localparam logic [7:0] OFS_PWR_INT    = 8'h10;
	localparam logic [7:0] OFS_PWR_FLT    = 8'h14;
	localparam logic [7:0] OFS_FREQ       = 8'h18;
	localparam logic [7:0] OFS_OFFTIME    = 8'h1c;
	localparam logic [7:0] OFS_STATUS     = 8'h20;
	localparam logic [7:0] OFS_CONFIG     = 8'h24;
	// Parameter frame byte positions inside a request or reply word
	localparam int FRM_GROUP_LSB   = 24;
	localparam int FRM_CHANNEL_LSB = 16;
	// Config register bits
	localparam int CFG_ORDER_BIT  = 0;
	localparam int CFG_REJECT_BIT = 8;
	// Status byte 0 bits
	localparam int S0_FIELDBUS = 0, S0_RELAYS = 2, S0_POWER = 3;
	localparam int S0_PULSED = 5, S0_READY = 7;
	// Status byte 1 bits
	localparam int S1_INTERLOCK = 0, S1_OVERTEMP = 1, S1_MAINS = 2;
	localparam int S1_LOGIC = 3, S1_NVQUEUE = 4;
	localparam int S1_WARNING = 6, S1_ALARM = 7;
	// Status byte 2 bits
	localparam int S2_VOLT = 0, S2_CURR = 1, S2_PWR = 2;
	localparam int S2_PLIM = 3, S2_END = 4, S2_ARC = 5;
	// Parameter groups and channels (read channel differs from set channel)
	localparam logic [7:0] GRP_STATUS  = 8'd1;
	localparam logic [7:0] GRP_POWER   = 8'd2;
	localparam logic [7:0] GRP_CURRENT = 8'd4;
	localparam logic [7:0] GRP_FREQ    = 8'd6;
	localparam logic [7:0] GRP_PULSE   = 8'd7;
	localparam logic [7:0] GRP_CONFIG  = 8'd12;
	localparam logic [7:0] CH_BYTE0 = 8'd4, CH_BYTE1 = 8'd8, CH_BYTE2 = 8'd16;
	localparam logic [7:0] CH_ACTUAL = 8'd4, CH_NOMINAL = 8'd8;
	localparam logic [7:0] CH_PULSE_READ = 8'd2, CH_PULSE_SET = 8'd3;
	localparam logic [7:0] CH_ISCALE_SET = 8'd1, CH_ISCALE_READ = 8'd2;
	localparam logic [7:0] CH_PSCALE_SET = 8'd3, CH_PSCALE_READ = 8'd4;
	localparam logic [7:0] CH_ORDER_SET  = 8'd5, CH_ORDER_READ  = 8'd6;
	// Reset values of the settings
	localparam logic [15:0] RST_ISCALE   = 16'h2710;
	localparam logic [15:0] RST_PSCALE   = 16'h2710;
	localparam logic [15:0] RST_FREQ_SET = 16'h0001;
	localparam logic [15:0] RST_OFF_SET  = 16'h000a;
	localparam logic        RST_ORDER    = 1'b0;
	// Divider iteration count
	localparam logic [5:0] DIV_STEPS = 6'd32;
	typedef enum {CONV_START_I, CONV_WAIT_I, CONV_START_P, CONV_WAIT_P} conv_t;
endpackage : fieldbus_image_pkg

//--- hw/fieldbus_process_data_image.sv
// Cyclic input image and integer parameter channel of the fieldbus slave
// Functional notes
// - current integer readout, two bytes, scale times actual over rated
// - current float readout is four bytes in the selected byte order
// - power integer readout, two bytes, scale times actual over rated
// - power float readout is four bytes in the selected byte order
// - pulsed units report pulse frequency in hertz, one up to rated
// - pulsed units report off-time in tenths of a microsecond, up to rated
// - three status bytes; byte zero bit 0 marks fieldbus control
// - byte zero bit 2 relays closed, bit 3 power on; 1,4,6 unused
// - byte zero bit 5 pulsed mode, bit 7 ready to turn on
// - byte one bits 0-4 flag interlock, overtemp, mains, logic, queue
// - byte one bit 6 any warning, bit 7 any alarm; bit 5 unused
// - byte two bits 0-2 flag voltage, current or power being limited
// - limit flags follow the actual limiting quantity, not selected mode
// - byte two bit 3 power limit, 4 process end, 5 arc warning
// - parameter frame is group, channel, then 16-bit value, both ways
// - separate read and set channels; sets in request, actuals in reply
// - two-byte integers travel most significant byte first
// - float byte order is selectable through the parameter channel
//
// The APB interface to the registers and the placing of the registers were decided locally.
module fieldbus_process_data_image
	import fieldbus_image_pkg::*;
#(
	parameter logic [15:0] RATED_CURRENT = 16'd1000, // Rated current units
	parameter logic [15:0] RATED_POWER   = 16'd1000, // Rated power units
	parameter logic [15:0] RATED_FREQ    = 16'd1000, // Rated pulse freq, Hz
	parameter logic [15:0] RATED_OFFTIME = 16'd1000, // Rated off-time counts
	parameter bit          PULSED_UNIT   = 1'b1      // Unit has pulse generator
) (
	input  wire logic        pclk,                  // APB clock
	input  wire logic        presetn,               // Async reset, low
	input  wire logic [7:0]  paddr,                 // APB byte address
	input  wire logic        psel,                  // APB select
	input  wire logic        penable,               // APB enable
	input  wire logic        pwrite,                // APB write
	input  wire logic [31:0] pwdata,                // APB write data
	output logic      [31:0] prdata,                // APB read data
	output logic             pready,                // APB ready
	output logic             pslverr,               // APB error
	input  wire logic [15:0] measured_current,      // Actual current
	input  wire logic [15:0] measured_power,        // Actual power
	input  wire logic [31:0] current_float,         // Actual current, float
	input  wire logic [31:0] power_float,           // Actual power, float
	input  wire logic [15:0] measured_freq,         // Pulse freq, Hz
	input  wire logic [15:0] measured_offtime,      // Off-time, 0.1 us
	input  wire logic        fieldbus_control,      // Fieldbus has control
	input  wire logic        relays_closed,         // Power relays closed
	input  wire logic        power_enabled,         // Output power on
	input  wire logic        pulsed_mode,           // Pulsed mode active
	input  wire logic        ready_to_run,          // Ready to turn on
	input  wire logic        interlock_open,        // Interlock loop open
	input  wire logic        overtemp,              // Unit overheated
	input  wire logic        mains_fault,           // Mains low or phase lost
	input  wire logic        logic_fault,           // Programmable logic fault
	input  wire logic        nv_queue_overload,     // NV write queue full
	input  wire logic        warning_active,        // Any warning
	input  wire logic        alarm_active,          // Any alarm
	input  wire logic        voltage_limiting_flag, // Voltage is limiting
	input  wire logic        current_limiting_flag, // Current is limiting
	input  wire logic        power_limiting_flag,   // Power is limiting
	input  wire logic        pulse_limit_flag,      // Avg power limits pulse
	input  wire logic        process_end_flag,      // Process timer ended
	input  wire logic        arc_warning_stage_one, // First arc warning
	output logic      [15:0] current_scale,         // Current full scale
	output logic      [15:0] power_scale,           // Power full scale
	output logic      [15:0] freq_setpoint,         // Pulse freq setpoint
	output logic      [15:0] offtime_setpoint,      // Off-time setpoint
	output logic             float_little_first     // Float byte order
);
	scale_if sif ();

	conv_t       conv_reg;
	logic [15:0] curr_int_reg;
	logic [15:0] pwr_int_reg;
	logic [31:0] curr_flt_reg;
	logic [31:0] pwr_flt_reg;
	logic [15:0] freq_reg;
	logic [15:0] offtime_reg;
	logic [23:0] status_reg;
	logic [31:0] request_reg;
	logic [31:0] reply_reg;
	logic        reject_reg;
	logic [15:0] iscale_reg;
	logic [15:0] pscale_reg;
	logic [15:0] freq_set_reg;
	logic [15:0] off_set_reg;
	logic        order_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic [31:0] curr_flt_next;
	logic [31:0] pwr_flt_next;
	logic [7:0]  status_b0;
	logic [7:0]  status_b1;
	logic [7:0]  status_b2;
	logic [7:0]  req_group;
	logic [7:0]  req_channel;
	logic [15:0] req_value;
	logic [15:0] param_value;
	logic        param_known;
	logic        setup;
	logic        access;
	logic        param_write;
	logic        mapped;
	logic [31:0] read_mux;

	scale_divider u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.sif     (sif.unit)
	);

	float_byte_order u_curr_order (
		.little_first (order_reg),
		.value_in     (current_float),
		.value_out    (curr_flt_next)
	);

	float_byte_order u_pwr_order (
		.little_first (order_reg),
		.value_in     (power_float),
		.value_out    (pwr_flt_next)
	);

	// Current and power share one divider, converted in turn
	assign sif.start = conv_reg == CONV_START_I || conv_reg == CONV_START_P;
	assign sif.scale = (conv_reg == CONV_START_P) ? pscale_reg : iscale_reg;
	assign sif.actual = (conv_reg == CONV_START_P) ? measured_power
		: measured_current;
	assign sif.rated = (conv_reg == CONV_START_P) ? RATED_POWER
		: RATED_CURRENT;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_reg <= CONV_START_I;
		end else begin
			case (conv_reg)
				CONV_START_I: conv_reg <= CONV_WAIT_I;
				CONV_WAIT_I:  conv_reg <= sif.done ? CONV_START_P : CONV_WAIT_I;
				CONV_START_P: conv_reg <= CONV_WAIT_P;
				CONV_WAIT_P:  conv_reg <= sif.done ? CONV_START_I : CONV_WAIT_P;
				default:      conv_reg <= CONV_START_I;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			curr_int_reg <= 16'h0;
			pwr_int_reg <= 16'h0;
		end else if (sif.done) begin
			if (conv_reg == CONV_WAIT_I)
				curr_int_reg <= sif.result;
			if (conv_reg == CONV_WAIT_P)
				pwr_int_reg <= sif.result;
		end
	end

	// Floats follow the order live, so a change takes effect next cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			curr_flt_reg <= 32'h0;
			pwr_flt_reg <= 32'h0;
		end else begin
			curr_flt_reg <= curr_flt_next;
			pwr_flt_reg <= pwr_flt_next;
		end
	end

	// Non-pulsed units read zero on the pulse readouts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_reg <= 16'h0;
			offtime_reg <= 16'h0;
		end else begin
			freq_reg <= !PULSED_UNIT ? 16'h0
				: (measured_freq > RATED_FREQ) ? RATED_FREQ
				: measured_freq;
			offtime_reg <= !PULSED_UNIT ? 16'h0
				: (measured_offtime > RATED_OFFTIME) ? RATED_OFFTIME
				: measured_offtime;
		end
	end

	always_comb begin
		status_b0 = 8'h0;
		status_b0[S0_FIELDBUS] = fieldbus_control;
		status_b0[S0_RELAYS] = relays_closed;
		status_b0[S0_POWER] = power_enabled;
		status_b0[S0_PULSED] = pulsed_mode && PULSED_UNIT;
		status_b0[S0_READY] = ready_to_run;
		status_b1 = 8'h0;
		status_b1[S1_INTERLOCK] = interlock_open;
		status_b1[S1_OVERTEMP] = overtemp;
		status_b1[S1_MAINS] = mains_fault;
		status_b1[S1_LOGIC] = logic_fault;
		status_b1[S1_NVQUEUE] = nv_queue_overload;
		status_b1[S1_WARNING] = warning_active;
		status_b1[S1_ALARM] = alarm_active;
		status_b2 = 8'h0;
		// Regulator's live limit, never the mode that was asked for
		status_b2[S2_VOLT] = voltage_limiting_flag;
		status_b2[S2_CURR] = current_limiting_flag;
		status_b2[S2_PWR] = power_limiting_flag;
		status_b2[S2_PLIM] = pulse_limit_flag;
		status_b2[S2_END] = process_end_flag;
		status_b2[S2_ARC] = arc_warning_stage_one;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_reg <= 24'h0;
		else
			status_reg <= {status_b0, status_b1, status_b2};
	end

	// Parameter request fields, value most significant byte first
	assign req_group = pwdata[FRM_GROUP_LSB +: 8];
	assign req_channel = pwdata[FRM_CHANNEL_LSB +: 8];
	assign req_value = pwdata[15:0];

	// Read channels return actuals; set channels echo the new value
	always_comb begin
		param_value = 16'h0;
		param_known = 1'b1;
		case ({req_group, req_channel})
			{GRP_STATUS, CH_BYTE0}:        param_value = {8'h0, status_reg[23:16]};
			{GRP_STATUS, CH_BYTE1}:        param_value = {8'h0, status_reg[15:8]};
			{GRP_STATUS, CH_BYTE2}:        param_value = {8'h0, status_reg[7:0]};
			{GRP_POWER, CH_ACTUAL}:        param_value = pwr_int_reg;
			{GRP_POWER, CH_NOMINAL}:       param_value = RATED_POWER;
			{GRP_CURRENT, CH_ACTUAL}:      param_value = curr_int_reg;
			{GRP_CURRENT, CH_NOMINAL}:     param_value = RATED_CURRENT;
			{GRP_FREQ, CH_PULSE_READ}:     param_value = freq_reg;
			{GRP_FREQ, CH_PULSE_SET}:      param_value = req_value;
			{GRP_PULSE, CH_PULSE_READ}:    param_value = offtime_reg;
			{GRP_PULSE, CH_PULSE_SET}:     param_value = req_value;
			{GRP_CONFIG, CH_ISCALE_SET}:   param_value = req_value;
			{GRP_CONFIG, CH_ISCALE_READ}:  param_value = iscale_reg;
			{GRP_CONFIG, CH_PSCALE_SET}:   param_value = req_value;
			{GRP_CONFIG, CH_PSCALE_READ}:  param_value = pscale_reg;
			{GRP_CONFIG, CH_ORDER_SET}:    param_value = {15'h0, req_value[0]};
			{GRP_CONFIG, CH_ORDER_READ}:   param_value = {15'h0, order_reg};
			default:                       param_known = 1'b0;
		endcase
	end

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign param_write = access && pwrite && paddr == OFS_REQUEST;

	always_comb begin
		mapped = 1'b1;
		read_mux = 32'h0;
		case (paddr)
			OFS_REQUEST:  read_mux = request_reg;
			OFS_REPLY:    read_mux = reply_reg;
			OFS_CURR_INT: read_mux = {16'h0, curr_int_reg};
			OFS_CURR_FLT: read_mux = curr_flt_reg;
			OFS_PWR_INT:  read_mux = {16'h0, pwr_int_reg};
			OFS_PWR_FLT:  read_mux = pwr_flt_reg;
			OFS_FREQ:     read_mux = {16'h0, freq_reg};
			OFS_OFFTIME:  read_mux = {16'h0, offtime_reg};
			OFS_STATUS:   read_mux = {8'h0, status_reg};
			OFS_CONFIG: begin
				read_mux[CFG_ORDER_BIT] = order_reg;
				read_mux[CFG_REJECT_BIT] = reject_reg;
			end
			default:      mapped = 1'b0;
		endcase
	end

	// Read data and error latched in setup, so the access phase is one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? 32'h0 : read_mux;
			pslverr_reg <= !mapped;
		end
	end

	// A write to the request word runs the parameter channel at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request_reg <= 32'h0;
			reply_reg <= 32'h0;
			reject_reg <= 1'b0;
		end else if (param_write) begin
			request_reg <= pwdata;
			reply_reg <= {req_group, req_channel, param_value};
			reject_reg <= !param_known;
		end
	end

	// Only defined set channels touch a setting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iscale_reg <= RST_ISCALE;
			pscale_reg <= RST_PSCALE;
		end else if (param_write) begin
			case ({req_group, req_channel})
				{GRP_CONFIG, CH_ISCALE_SET}: iscale_reg <= req_value;
				{GRP_CONFIG, CH_PSCALE_SET}: pscale_reg <= req_value;
				default:                     iscale_reg <= iscale_reg;
			endcase
		end
	end

	// Setpoints kept as written; the pulse stage does its own limiting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_set_reg <= RST_FREQ_SET;
			off_set_reg <= RST_OFF_SET;
		end else if (param_write) begin
			case ({req_group, req_channel})
				{GRP_FREQ, CH_PULSE_SET}:  freq_set_reg <= req_value;
				{GRP_PULSE, CH_PULSE_SET}: off_set_reg <= req_value;
				default:                   freq_set_reg <= freq_set_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			order_reg <= RST_ORDER;
		else if (param_write && {req_group, req_channel}
				== {GRP_CONFIG, CH_ORDER_SET})
			order_reg <= req_value[0];
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg && access;
	assign pready = access;
	assign current_scale = iscale_reg;
	assign power_scale = pscale_reg;
	assign freq_setpoint = freq_set_reg;
	assign offtime_setpoint = off_set_reg;
	assign float_little_first = order_reg;
endmodule : fieldbus_process_data_image

//--- hw/float_byte_order.sv
// Places a float word's bytes in the selected transfer order
module float_byte_order (
	input  wire logic        little_first, // 1: least significant byte first
	input  wire logic [31:0] value_in,     // Float, natural order
	output logic      [31:0] value_out     // Float, frame order
);
	for (genvar b = 0; b < 4; b++) begin : g_byte
		assign value_out[8*b +: 8] = little_first ? value_in[8*(3-b) +: 8]
			: value_in[8*b +: 8];
	end
endmodule : float_byte_order

//--- hw/scale_divider.sv
// Sequential scaling unit: full-scale count times actual over rated
module scale_divider
	import fieldbus_image_pkg::*;
(
	input wire logic pclk,    // Clock
	input wire logic presetn, // Async reset, active low
	scale_if.unit    sif      // Conversion handshake
);
	logic [31:0] quot_reg;
	logic [16:0] rem_reg;
	logic [15:0] div_reg;
	logic [5:0]  count_reg;
	logic        busy_reg;
	logic        done_reg;
	logic [15:0] result_reg;
	logic [16:0] rem_shift;
	logic        fits;

	assign rem_shift = {rem_reg[15:0], quot_reg[31]};
	assign fits = rem_shift >= {1'b0, div_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quot_reg <= 32'h0;
			rem_reg <= 17'h0;
			div_reg <= 16'h0;
			count_reg <= 6'h0;
			busy_reg <= 1'b0;
		end else if (sif.start && !busy_reg) begin
			quot_reg <= {16'h0, sif.scale} * {16'h0, sif.actual};
			rem_reg <= 17'h0;
			div_reg <= sif.rated;
			count_reg <= DIV_STEPS;
			busy_reg <= 1'b1;
		end else if (busy_reg) begin
			quot_reg <= {quot_reg[30:0], fits};
			rem_reg <= fits ? rem_shift - {1'b0, div_reg} : rem_shift;
			count_reg <= count_reg - 6'd1;
			busy_reg <= count_reg != 6'd1;
		end
	end

	// Results too large for 16 bits saturate rather than wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
			result_reg <= 16'h0;
		end else begin
			done_reg <= busy_reg && count_reg == 6'd1;
			if (busy_reg && count_reg == 6'd1)
				result_reg <= (quot_reg[30:15] != 16'h0) ? 16'hffff
					: {quot_reg[14:0], fits};
		end
	end

	assign sif.done = done_reg;
	assign sif.result = result_reg;
endmodule : scale_divider

//--- hw/scale_if.sv
// Handshake between the image builder and the scaling divider
interface scale_if;
	logic        start;   // Request a conversion
	logic        done;    // One-cycle pulse, result valid
	logic [15:0] scale;   // Full-scale count
	logic [15:0] actual;  // Measured value
	logic [15:0] rated;   // Rated value, nonzero
	logic [15:0] result;  // scale * actual / rated, saturated
	modport master (output start, scale, actual, rated, input done, result);
	modport unit (input start, scale, actual, rated, output done, result);
endinterface : scale_if

//--- tb/fieldbus_image_properties.sv
// Port assertions for the fieldbus process data image block
module fieldbus_image_properties
	import fieldbus_image_pkg::*;
#(
	parameter logic [15:0] RATED_FREQ = 16'd1000 // Rated pulse freq
) (
	input wire logic        pclk,               // Clock
	input wire logic        presetn,            // Reset, low
	input wire logic [7:0]  paddr,              // Address
	input wire logic        psel,               // Select
	input wire logic        penable,            // Enable
	input wire logic        pwrite,             // Write
	input wire logic [31:0] pwdata,             // Write data
	input wire logic [31:0] prdata,             // Read data
	input wire logic [15:0] current_scale,      // Setting
	input wire logic [15:0] power_scale,        // Setting
	input wire logic [15:0] freq_setpoint,      // Setting
	input wire logic [15:0] offtime_setpoint,   // Setting
	input wire logic        float_little_first  // Setting
);
	logic        acc;
	logic        wr;
	logic [15:0] gc;
	logic        setp;
	assign acc = psel && penable;
	assign wr = acc && pwrite && paddr == OFS_REQUEST;
	assign gc = pwdata[31:16];
	assign setp = gc == {GRP_CONFIG, CH_ISCALE_SET}
		|| gc == {GRP_CONFIG, CH_PSCALE_SET}
		|| gc == {GRP_CONFIG, CH_ORDER_SET}
		|| gc == {GRP_FREQ, CH_PULSE_SET} || gc == {GRP_PULSE, CH_PULSE_SET};
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_iscale_set: assert property (
		wr && gc == {GRP_CONFIG, CH_ISCALE_SET}
		|=> current_scale == $past(pwdata[15:0]))
		else $error("current scale not loaded");
	a_pscale_set: assert property (
		wr && gc == {GRP_CONFIG, CH_PSCALE_SET}
		|=> power_scale == $past(pwdata[15:0]))
		else $error("power scale not loaded");
	a_order_set: assert property (
		wr && gc == {GRP_CONFIG, CH_ORDER_SET}
		|=> float_little_first == $past(pwdata[0]))
		else $error("byte order not loaded");
	a_freq_set: assert property (
		wr && gc == {GRP_FREQ, CH_PULSE_SET}
		|=> freq_setpoint == $past(pwdata[15:0]))
		else $error("freq setpoint not loaded");
	a_offtime_set: assert property (
		wr && gc == {GRP_PULSE, CH_PULSE_SET}
		|=> offtime_setpoint == $past(pwdata[15:0]))
		else $error("off-time setpoint not loaded");
	a_unknown_keeps: assert property (
		wr && !setp |=> $stable({current_scale, power_scale,
		freq_setpoint, offtime_setpoint, float_little_first}))
		else $error("setting moved without set request");
	a_status_spare: assert property (
		acc && !pwrite && paddr == OFS_STATUS |-> prdata[31:24] == 8'h00
		&& {prdata[22], prdata[20], prdata[17], prdata[13]} == 4'h0
		&& prdata[7:6] == 2'h0)
		else $error("unused status bit set");
	a_freq_range: assert property (
		acc && !pwrite && paddr == OFS_FREQ
		|-> prdata <= {16'h0000, RATED_FREQ})
		else $error("frequency above rated");
endmodule : fieldbus_image_properties

bind fieldbus_process_data_image fieldbus_image_properties #(
	.RATED_FREQ(RATED_FREQ)
) fieldbus_image_properties_i (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.current_scale(current_scale), .power_scale(power_scale),
	.freq_setpoint(freq_setpoint), .offtime_setpoint(offtime_setpoint),
	.float_little_first(float_little_first)
);

//--- tb/fieldbus_process_data_image_tb.sv
// Self-checking bench for the fieldbus process data image block
module fieldbus_process_data_image_tb
	import fieldbus_image_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd, fcur = 32'h0, fpwr = 32'h0;
	logic        pready, pslverr, err, ord, load_on = 1'b1;
	logic [15:0] mcur = 16'h0, mpwr = 16'h0, mfrq = 16'h1, moff = 16'ha;
	logic [15:0] cs, ps, fs, os;
	logic [17:0] flags = 18'h0, st;
	int          err_total = 0, n_tests = 0, cyc = 0;
	int          pos [18] = '{16, 18, 19, 21, 23, 8, 9, 10, 11, 12, 14, 15,
		0, 1, 2, 3, 4, 5};
	always #20 pclk = ~pclk;
	plant_model plant_model_i (.flags(flags), .load_on(load_on), .st(st));
	fieldbus_process_data_image fieldbus_process_data_image_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.measured_current(mcur), .measured_power(mpwr),
		.current_float(fcur), .power_float(fpwr),
		.measured_freq(mfrq), .measured_offtime(moff),
		.fieldbus_control(st[0]), .relays_closed(st[1]),
		.power_enabled(st[2]), .pulsed_mode(st[3]), .ready_to_run(st[4]),
		.interlock_open(st[5]), .overtemp(st[6]), .mains_fault(st[7]),
		.logic_fault(st[8]), .nv_queue_overload(st[9]),
		.warning_active(st[10]), .alarm_active(st[11]),
		.voltage_limiting_flag(st[12]), .current_limiting_flag(st[13]),
		.power_limiting_flag(st[14]), .pulse_limit_flag(st[15]),
		.process_end_flag(st[16]), .arc_warning_stage_one(st[17]),
		.current_scale(cs), .power_scale(ps), .freq_setpoint(fs),
		.offtime_setpoint(os), .float_little_first(ord));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc
	task automatic par(input logic [7:0] g, c, input logic [15:0] v, x);
		apb(1'b1, OFS_REQUEST, {g, c, v});
		rdc(OFS_REPLY, {g, c, x});
	endtask : par
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		tick(3);
		presetn <= 1'b1;
		chk({cs, ps}, {RST_ISCALE, RST_PSCALE});
		mcur <= 16'd500;
		mpwr <= 16'd1000;
		fcur <= 32'h11223344;
		fpwr <= 32'h55667788;
		tick(100);
		rdc(OFS_CURR_INT, 32'h00001388);
		rdc(OFS_PWR_INT, 32'h00002710);
		par(GRP_POWER, CH_ACTUAL, 16'h0000, 16'h2710);
		par(GRP_POWER, CH_NOMINAL, 16'h0000, 16'h03e8);
		par(GRP_CURRENT, CH_NOMINAL, 16'h0000, 16'h03e8);
		rdc(OFS_CURR_FLT, 32'h11223344);
		par(GRP_CONFIG, CH_ORDER_SET, 16'h0001, 16'h0001);
		chk({31'h0, ord}, 32'h1);
		rdc(OFS_PWR_FLT, 32'h88776655);
		par(GRP_CONFIG, CH_ORDER_READ, 16'h0000, 16'h0001);
		par(GRP_CONFIG, CH_ORDER_SET, 16'h0000, 16'h0000);
		$display("test readouts done");
		// Above rated, so the product overflows the field
		par(GRP_CONFIG, CH_ISCALE_SET, 16'hffff, 16'hffff);
		mcur <= 16'd1001;
		tick(100);
		rdc(OFS_CURR_INT, 32'h0000ffff);
		par(GRP_CONFIG, CH_ISCALE_SET, 16'h0064, 16'h0064);
		par(GRP_CONFIG, CH_PSCALE_SET, 16'h03e8, 16'h03e8);
		mcur <= 16'd999;
		tick(100);
		par(GRP_POWER, CH_ACTUAL, 16'h0000, 16'h03e8);
		par(GRP_CONFIG, CH_PSCALE_READ, 16'h0000, 16'h03e8);
		par(GRP_CURRENT, CH_ACTUAL, 16'h0000, 16'h0063);
		par(GRP_CONFIG, CH_ISCALE_READ, 16'h0000, 16'h0064);
		$display("test scaling done");
		mfrq <= 16'd1001;
		tick(4);
		rdc(OFS_FREQ, 32'h000003e8);
		par(GRP_PULSE, CH_PULSE_READ, 16'h0000, 16'h000a);
		mfrq <= 16'h0001;
		moff <= 16'hffff;
		tick(4);
		par(GRP_FREQ, CH_PULSE_READ, 16'h0000, 16'h0001);
		rdc(OFS_OFFTIME, 32'h000003e8);
		par(GRP_FREQ, CH_PULSE_SET, 16'h1388, 16'h1388);
		par(GRP_PULSE, CH_PULSE_SET, 16'h0019, 16'h0019);
		chk({fs, os}, 32'h13880019);
		$display("test pulse done");
		for (int i = 0; i < 18; i++) begin
			flags <= 18'h1 << i;
			tick(4);
			rdc(OFS_STATUS, 32'h1 << pos[i]);
		end
		flags <= 18'h3ffff;
		tick(4);
		par(GRP_STATUS, CH_BYTE0, 16'h0, 16'h00ad);
		par(GRP_STATUS, CH_BYTE1, 16'h0, 16'h00df);
		par(GRP_STATUS, CH_BYTE2, 16'h0, 16'h003f);
		load_on <= 1'b0;
		flags <= 18'h04000;
		tick(4);
		rdc(OFS_STATUS, 32'h00000001);
		$display("test status done");
		par(GRP_FREQ, CH_ISCALE_SET, 16'h1234, 16'h0000);
		rdc(OFS_CONFIG, 32'h00000100);
		chk({cs, fs}, 32'h00641388);
		chk({ps, os}, 32'h03e80019);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test refusal done");
		end_sim();
	end
endmodule : fieldbus_process_data_image_tb

//--- tb/plant_model.sv
// Far-side power stage model driving the status pins
module plant_model (
	input  wire logic [17:0] flags,   // Flag states to report
	input  wire logic        load_on, // Load connected
	output logic      [17:0] st       // Pins seen by the block
);
	timeunit 1ns;
	timeprecision 1ns;
	// Without load the voltage loop limits, even in power mode
	always_comb begin
		st = flags;
		if (!load_on) begin
			st[12] = 1'b1;
			st[14] = 1'b0;
		end
	end
endmodule : plant_model
